// >>> logic/swp_pkg.sv
// Purpose: shared constants and types for the single-wire push-pull master
// Assumes: 25 MHz pclk, 20 kHz push bit rate
// Notes: all offsets, field positions, reset values and counts live here
package swp_pkg;

  // clock and slot timing
  localparam int CLK_MHZ = 25;
  localparam int BIT_RATE_HZ = 20000;
  localparam int SLOT_NS = 1000000000 / (2 * BIT_RATE_HZ);
  localparam int SLOT_CYC = SLOT_NS * CLK_MHZ / 1000;
  localparam int EOF_TOL_PCT = 1;
  localparam int SLOT_MIN_CYC = (SLOT_CYC * (100 - EOF_TOL_PCT) + 99) / 100;
  localparam int SLOT_MAX_CYC = SLOT_CYC * (100 + EOF_TOL_PCT) / 100;
  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] SLOT_LAST = TMR_W'(SLOT_CYC - 1);
  localparam logic [TMR_W-1:0] SLOT_MID = TMR_W'(SLOT_CYC / 2 - 1);
  localparam logic [10:0] EDGE_MIN = 11'(SLOT_MIN_CYC);
  localparam logic [10:0] EDGE_MAX = 11'(SLOT_MAX_CYC);

  // frame layout, counted in time slots
  localparam int DATA_BITS = 5;
  localparam int ADDR_BITS = 3;
  localparam int PULL_BITS = 3;
  localparam logic [4:0] START_LAST = 5'h02;
  localparam logic [4:0] SYNC_LAST = 5'h01;
  localparam logic [4:0] PUSH_LAST = 5'(2 * (DATA_BITS + ADDR_BITS) - 1);
  localparam logic [4:0] PULL_LAST = 5'(PULL_BITS - 1);
  localparam logic [4:0] EOF_LAST = 5'h07;
  localparam logic [3:0] EOF_EDGES_MIN = 4'h4;

  // register offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;

  // control field positions and reset values
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [7:0] DATA_RST = 8'h00;

  // status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_VALID = 2;
  localparam int STAT_CODE_ERR = 3;
  localparam int STAT_EOF_ERR = 4;

  // frame sequencer states, gray along the frame
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_PSYNC = 3'b011,
    ST_PUSH = 3'b010,
    ST_PULLSYNC = 3'b110,
    ST_PULL = 3'b111,
    ST_EOF = 3'b101
  } swp_state_e;

endpackage

// >>> logic/swp_slot_timer.sv
// Purpose: time slot strobes for the frame sequencer
// Assumes: restart is a one-cycle pulse at frame launch
// Notes: slot_mid marks the receive sample point
`timescale 1ns/10ps
module swp_slot_timer
  import swp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  input wire logic run,
  // slot strobes
  output logic slot_mid,
  output logic slot_end
);

  logic [TMR_W-1:0] cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= '0;
    end
    else if (restart || !run || cnt == SLOT_LAST)
    begin
      cnt <= '0;
    end
    else
    begin
      cnt <= cnt + 1'b1;
    end
  end

  assign slot_mid = run && (cnt == SLOT_MID);
  assign slot_end = run && (cnt == SLOT_LAST);

endmodule // swp_slot_timer

// >>> logic/swp_master.sv
// Purpose: single-wire push-pull bus master with APB register access
// Assumes: slave drives pull data and end-of-frame on the receive pin
// Notes: one frame at a time; data writes during a frame are dropped
//
// How it works
// - a data write launches a frame when the sequencer is idle and transmit is enabled
// - start holds the line low for three time slots
// - push sync follows the start as biphase zero
// - five push data bits follow the sync, biphase coded
// - three push address bits follow the data, biphase coded
// - data byte low five bits are data, top three bits address
// - master sends pull sync as biphase one after last address bit
// - pull data is NRZ, one bit sampled mid-slot per slot
// - received pull bits land in the data register low byte
// - each push bit spans two slots, zero high-low, one low-high
// - receive path is cut off during the whole push field
// - push leaves on the transmit pin, pull enters on the receive pin
// - three address bits reach at most eight slaves
// - slot lasts half a 20 kHz push bit
// - frame valid only with a good code and a square wave end
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module swp_master
  import swp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  output logic serial_out_pin,
  input wire logic serial_in_pin
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [4:0] last_slot(input swp_state_e s);
    unique case (s)
      ST_START: last_slot = START_LAST;
      ST_PSYNC: last_slot = SYNC_LAST;
      ST_PUSH: last_slot = PUSH_LAST;
      ST_PULLSYNC: last_slot = SYNC_LAST;
      ST_PULL: last_slot = PULL_LAST;
      default: last_slot = EOF_LAST;
    endcase
  endfunction

  swp_state_e state;
  logic [4:0] slot_idx;
  logic [7:0] push_byte;
  logic [PULL_BITS-1:0] pull_shift;
  logic [7:0] pull_data;
  logic [1:0] ctrl;
  logic done;
  logic frame_valid;
  logic code_err;
  logic eof_err;
  logic rx_s1;
  logic rx_s2;
  logic rx_prev;
  logic rx_active;
  logic rx_path;
  logic rx_edge;
  logic [10:0] ecnt;
  logic seen_edge;
  logic [3:0] good_edges;
  logic eof_bad;
  logic slot_mid;
  logic slot_end;
  logic launch;
  logic acc;
  logic wr_data;
  logic rd_data;
  logic mapped;
  logic push_bit;
  logic next_tx;
  logic code_ok;
  logic eof_done;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign acc = psel && penable;
  assign mapped = hit(paddr, OFS_DATA) || hit(paddr, OFS_CTRL)
                  || hit(paddr, OFS_STAT);
  assign wr_data = acc && pwrite && hit(paddr, OFS_DATA);
  assign rd_data = acc && !pwrite && hit(paddr, OFS_DATA);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign launch = wr_data && ctrl[CTRL_TX_EN] && (state == ST_IDLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
    end
    else if (psel && !penable && !pwrite)
    begin
      if (hit(paddr, OFS_DATA))
      begin
        prdata <= {24'h000000, pull_data};
      end
      else if (hit(paddr, OFS_CTRL))
      begin
        prdata <= {30'h0, ctrl};
      end
      else if (hit(paddr, OFS_STAT))
      begin
        prdata <= {27'h0, eof_err, code_err, frame_valid, done,
                   state != ST_IDLE};
      end
      else
      begin
        prdata <= '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RST;
    end
    else if (acc && pwrite && hit(paddr, OFS_CTRL))
    begin
      ctrl <= pwdata[1:0];
    end
  end

  // push byte only taken at launch, busy writes dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      push_byte <= DATA_RST;
    end
    else if (launch)
    begin
      push_byte <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  swp_slot_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .restart(launch),
    .run(state != ST_IDLE),
    .slot_mid(slot_mid),
    .slot_end(slot_end)
  );

  assign eof_done = slot_end && (state == ST_EOF) && (slot_idx == EOF_LAST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      slot_idx <= '0;
    end
    else if (launch)
    begin
      state <= ST_START;
      slot_idx <= '0;
    end
    else if (slot_end && state != ST_IDLE)
    begin
      if (slot_idx == last_slot(state))
      begin
        slot_idx <= '0;
        unique case (state)
          ST_START: state <= ST_PSYNC;
          ST_PSYNC: state <= ST_PUSH;
          ST_PUSH: state <= ST_PULLSYNC;
          ST_PULLSYNC: state <= ST_PULL;
          ST_PULL: state <= ST_EOF;
          default: state <= ST_IDLE;
        endcase
      end
      else
      begin
        slot_idx <= slot_idx + 1'b1;
      end
    end
  end

  assign push_bit = push_byte[slot_idx[3:1]];

  always_comb
  begin
    unique case (state)
      ST_IDLE: next_tx = 1'b1;
      ST_START: next_tx = 1'b0;
      ST_PSYNC: next_tx = (slot_idx == '0);
      ST_PUSH: next_tx = push_bit ^ !slot_idx[0];
      ST_PULLSYNC: next_tx = (slot_idx != '0);
      ST_PULL: next_tx = 1'b1;
      ST_EOF: next_tx = 1'b1;
      default: next_tx = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_out_pin <= 1'b1;
    end
    else
    begin
      serial_out_pin <= next_tx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_s1 <= serial_in_pin;
      rx_s2 <= rx_s1;
      rx_prev <= rx_path;
    end
  end

  assign rx_active = ctrl[CTRL_RX_EN] && (state == ST_PULL || state == ST_EOF);
  assign rx_path = rx_active ? rx_s2 : 1'b1;
  assign rx_edge = rx_path != rx_prev;
  assign code_ok = (pull_shift != '1) && (pull_shift != '0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pull_shift <= '0;
      pull_data <= DATA_RST;
    end
    else if (state == ST_PULL && slot_mid)
    begin
      pull_shift <= {rx_path, pull_shift[PULL_BITS-1:1]};
    end
    else if (state == ST_PULL && slot_end && slot_idx == PULL_LAST)
    begin
      pull_data <= {{(8 - PULL_BITS){1'b0}}, pull_shift};
    end
  end

  // end-of-frame edge spacing check
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ecnt <= '0;
      seen_edge <= 1'b0;
      good_edges <= '0;
      eof_bad <= 1'b0;
    end
    else if (state != ST_EOF)
    begin
      ecnt <= '0;
      seen_edge <= 1'b0;
      good_edges <= '0;
      eof_bad <= 1'b0;
    end
    else if (rx_edge)
    begin
      ecnt <= '0;
      seen_edge <= 1'b1;
      if (seen_edge && ecnt >= EDGE_MIN && ecnt <= EDGE_MAX)
      begin
        good_edges <= (good_edges == '1) ? good_edges : good_edges + 1'b1;
      end
      else if (seen_edge)
      begin
        eof_bad <= 1'b1;
      end
    end
    else if (ecnt != '1)
    begin
      ecnt <= ecnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame status

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_valid <= 1'b0;
      code_err <= 1'b0;
      eof_err <= 1'b0;
    end
    else if (launch)
    begin
      frame_valid <= 1'b0;
      code_err <= 1'b0;
      eof_err <= 1'b0;
    end
    else if (eof_done)
    begin
      frame_valid <= code_ok && !eof_bad
                     && good_edges >= EOF_EDGES_MIN;
      code_err <= !code_ok;
      eof_err <= eof_bad || good_edges < EOF_EDGES_MIN;
    end
  end

  // done is set at frame end, cleared by a data read; set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done <= 1'b0;
    end
    else if (eof_done)
    begin
      done <= 1'b1;
    end
    else if (rd_data)
    begin
      done <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_line_high: assert property (
    state == ST_IDLE && $past(state) == ST_IDLE |=> serial_out_pin)
    else $error("line not high while idle");
  a_start_three_slots: assert property (
    state == ST_START && slot_end && slot_idx == 5'h02 |=> state == ST_PSYNC)
    else $error("start not three slots");
  a_start_low: assert property (
    state == ST_START |=> !serial_out_pin)
    else $error("start slot not low");
  a_push_sync_zero: assert property (
    state == ST_PSYNC && slot_idx == 5'h01 |=> !serial_out_pin)
    else $error("push sync second half not low");
  a_push_biphase: assert property (
    state == ST_PUSH && !slot_idx[0] && !slot_end
    |=> serial_out_pin == !push_byte[slot_idx[3:1]])
    else $error("push bit first half wrong");
  a_push_length: assert property (
    state == ST_PUSH && slot_end && slot_idx == 5'h0F |=> state == ST_PULLSYNC)
    else $error("push field length wrong");
  a_pull_sync_one: assert property (
    state == ST_PULLSYNC && slot_idx == 5'h00 |=> !serial_out_pin)
    else $error("pull sync first half not low");
  a_rx_blocked: assert property (
    state inside {ST_START, ST_PSYNC, ST_PUSH, ST_PULLSYNC} |-> rx_path)
    else $error("receive path open during push");
  a_write_launch: assert property (
    wr_data && ctrl[0] && state == ST_IDLE |=> state == ST_START
    && push_byte == $past(pwdata[7:0]))
    else $error("data write did not launch frame");
  a_busy_drop: assert property (
    wr_data && state != ST_IDLE |=> $stable(push_byte))
    else $error("push byte changed during frame");
  a_valid_code: assert property (
    $rose(frame_valid) |-> pull_data[2:0] != 3'h7 && pull_data[2:0] != 3'h0)
    else $error("valid with forbidden code");

endmodule // swp_master

// >>> tb/swp_slave_model.sv
// Purpose: slave device model on the single-wire bus
// Assumes: line idles high through the pull-up
// Notes: records push slot levels, answers pull and end of frame
`timescale 1ns/10ps
module swp_slave_model
  import swp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bus line
  input wire logic line_tx,
  output logic line_rx,
  // reply control
  input wire logic [2:0] reply,
  input wire logic eof_good,
  // push slot levels seen
  output logic [22:0] seen
);
  logic active;
  int pos;
  int slot;
  logic drv;
  ////////////////////////////////////////////////////////////////////////
  // slot tracking from the start edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active <= 1'b0;
      pos <= 0;
      slot <= 0;
      seen <= '0;
    end
    else if (!active)
    begin
      active <= !line_tx;
      pos <= 1;
      slot <= 0;
    end
    else if (pos == SLOT_CYC - 1)
    begin
      pos <= 0;
      slot <= slot + 1;
      active <= slot < 33;
    end
    else
    begin
      pos <= pos + 1;
      if (pos == SLOT_CYC / 2 && slot < 23)
        seen[slot] <= line_tx;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // answer after the push field, wired-and line
  always_comb
  begin
    drv = 1'b1;
    if (active && slot >= 23 && slot <= 25)
      drv = reply[slot - 23];
    else if (active && slot >= 26 && eof_good)
      drv = slot[0];
  end
  assign line_rx = line_tx & drv;
endmodule // swp_slave_model

// >>> tb/tb.sv
// Purpose: self-checking bench for the push-pull master
// Assumes: apb master tasks, slave model on the line
// Notes: four frames with good and bad pull codes, one with receive off
`timescale 1ns/10ps
module tb
  import swp_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic pready;
  logic pslverr;
  logic e;
  logic tx;
  logic rx;
  logic [2:0] reply = 3'h0;
  logic eof_good = 1'b1;
  logic [22:0] seen;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #20 pclk = ~pclk;
  swp_master dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_out_pin(tx), .serial_in_pin(rx));
  swp_slave_model slave_u (.pclk(pclk), .presetn(presetn), .line_tx(tx),
    .line_rx(rx), .reply(reply), .eof_good(eof_good), .seen(seen));
  ////////////////////////////////////////////////////////////////////////
  // reporting
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      bad_count++;
      $display("wrong value at %0t: run too long", $time);
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // apb access, entered just after a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
    input string w);
    apb(1'b0, a, 32'h0);
    chk(r & m, x, w);
  endtask
  task wait_idle;
    r = 32'h1;
    while (r[STAT_BUSY] !== 1'b0)
    begin
      repeat (50) @(posedge pclk);
      apb(1'b0, OFS_STAT, 32'h0);
    end
  endtask
  function automatic logic [22:0] exp_slots(input logic [7:0] b);
    logic [22:0] v;
    v = 23'h400008;
    for (int i = 0; i < 8; i++)
    begin
      v[5 + 2 * i] = ~b[i];
      v[6 + 2 * i] = b[i];
    end
    return v;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // one frame, with a dropped write while busy
  task frame(input logic [7:0] b, input logic [2:0] c, input logic eg,
    input logic [31:0] st);
    reply <= c;
    eof_good <= eg;
    apb(1'b1, OFS_DATA, {24'h0, b});
    rd_chk(OFS_STAT, 32'h1, 32'h1, "busy");
    apb(1'b1, OFS_DATA, 32'h000000FF);
    wait_idle();
    chk({9'h0, seen}, {9'h0, exp_slots(b)}, "slots");
    rd_chk(OFS_STAT, 32'h1F, st, "status");
    rd_chk(OFS_DATA, 32'hFFFFFFFF, {29'h0, c}, "pull");
    rd_chk(OFS_STAT, 32'h2, 32'h0, "done clear");
    $display("test frame %h done", b);
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, tx}, 32'h1, "idle line");
    rd_chk(OFS_DATA, 32'hFFFFFFFF, {24'h0, DATA_RST}, "data reset");
    rd_chk(OFS_CTRL, 32'hFFFFFFFF, {30'h0, CTRL_RST}, "ctrl reset");
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    apb(1'b1, OFS_STAT, 32'h1F);
    rd_chk(OFS_STAT, 32'hFFFFFFFF, 32'h0, "status read only");
    apb(1'b1, OFS_DATA, 32'hA5);
    rd_chk(OFS_STAT, 32'h1, 32'h0, "no launch");
    chk({31'h0, tx}, 32'h1, "line still idle");
    apb(1'b1, OFS_CTRL, 32'h3);
    rd_chk(OFS_CTRL, 32'h3, 32'h3, "ctrl");
    chk({31'h0, e}, 32'h0, "mapped no error");
    $display("test registers done");
    frame(8'hA5, 3'h5, 1'b1, 32'h06);
    frame(8'h3C, 3'h7, 1'b0, 32'h1A);
    frame(8'hE0, 3'h0, 1'b1, 32'h0A);
    apb(1'b1, OFS_CTRL, 32'h1);
    frame(8'h5A, 3'h7, 1'b1, 32'h1A);
    finish_test;
  end
endmodule // tb
